// *** hdl/dse_pkg.sv ***
// Package with constants and types of the DPSK scrambler and differential codec.
package dse_pkg;

  // Bit rate, baud rate and the 200 MHz system clock.
  localparam int unsigned BIT_RATE_HZ      = 1200;
  localparam int unsigned BAUD_RATE_HZ     = 600;
  localparam int unsigned SYS_CLK_HZ       = 200000000;
  localparam int unsigned BITS_PER_SYMBOL  = BIT_RATE_HZ / BAUD_RATE_HZ;

  // Scrambler taps, counted in bit periods back from the current bit.
  localparam int unsigned SCR_LEN          = 17;
  localparam int unsigned SCR_TAP_A        = 14;
  localparam int unsigned SCR_TAP_B        = 17;
  localparam logic [16:0] SCR_RESET        = 17'h00000;

  // Total phase in quarter turns: 0, 90, 180 and 270 degrees.
  typedef enum logic [1:0] {
    DSE_PH_0   = 2'b00,
    DSE_PH_90  = 2'b01,
    DSE_PH_180 = 2'b10,
    DSE_PH_270 = 2'b11
  } dse_phase_t;

  localparam dse_phase_t PHASE_RESET       = DSE_PH_0;

  // Two's complement symbol component: +1, 0 or -1.
  localparam logic [1:0] AMP_POS           = 2'h1;
  localparam logic [1:0] AMP_ZERO          = 2'h0;
  localparam logic [1:0] AMP_NEG           = 2'h3;

  typedef struct packed {
    logic [1:0] i;
    logic [1:0] q;
  } dse_iq_t;

  // Dibit with the earlier bit in the upper position.
  typedef struct packed {
    logic       valid;
    logic [1:0] bits;
  } dse_dibit_t;

  // Dibit to phase change: 00->90, 01->0, 10->180, 11->270 degrees.
  function automatic dse_phase_t dibit_to_delta(input logic [1:0] d);
    case (d)
      2'h0:    dibit_to_delta = DSE_PH_90;
      2'h1:    dibit_to_delta = DSE_PH_0;
      2'h2:    dibit_to_delta = DSE_PH_180;
      default: dibit_to_delta = DSE_PH_270;
    endcase
  endfunction

  // Inverse of dibit_to_delta.
  function automatic logic [1:0] delta_to_dibit(input dse_phase_t p);
    case (p)
      DSE_PH_90:  delta_to_dibit = 2'h0;
      DSE_PH_0:   delta_to_dibit = 2'h1;
      DSE_PH_180: delta_to_dibit = 2'h2;
      default:    delta_to_dibit = 2'h3;
    endcase
  endfunction

endpackage

// *** hdl/dse_rx_decoder.sv ***
// Receive-side differential decoder from received I/Q points back to dibits.
`timescale 1ns/1ps
module dse_rx_decoder
  import dse_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Received point, one per baud
  input  wire logic       rx_stb,
  input  wire dse_iq_t    rx_iq,
  // Recovered dibit
  output dse_dibit_t      dibit
);

  typedef struct packed {
    dse_phase_t prev;
    dse_dibit_t out;
  } dse_rx_state_t;

  dse_rx_state_t s_q;
  dse_rx_state_t s_d;
  dse_phase_t    cur;

  always_comb begin
    s_d           = s_q;
    s_d.out.valid = 1'b0;
    if (rx_iq.i == AMP_POS) begin
      cur = DSE_PH_0;
    end else if (rx_iq.q == AMP_NEG) begin
      cur = DSE_PH_90;
    end else if (rx_iq.i == AMP_NEG) begin
      cur = DSE_PH_180;
    end else begin
      cur = DSE_PH_270;
    end
    if (rx_stb) begin
      s_d.out.bits  = delta_to_dibit(dse_phase_t'(2'(cur - s_q.prev)));
      s_d.out.valid = 1'b1;
      s_d.prev      = cur;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{prev: PHASE_RESET, out: '{valid: 1'b0, bits: 2'h0}};
    end else begin
      s_q <= s_d;
    end
  end

  assign dibit = s_q.out;

endmodule // dse_rx_decoder

// *** hdl/dse_codec.sv ***
// Top of the DPSK bit scrambler, dibit encoder and receive decoder.
`timescale 1ns/1ps
// Contract
// - One I/Q symbol is emitted per baud, 600 symbols per second.
// - Two consecutive scrambled bits form one dibit per symbol, giving 1200 bit/s.
// - Dibit 00 gives 90, 01 gives 0, 10 gives 180 and 11 gives 270 degrees of phase change.
// - Total phase is advanced once per symbol by the phase change modulo 360 degrees.
// - Total phase 0, 90, 180, 270 degrees maps to (1,0), (0,-1), (-1,0), (0,1).
// - Each scrambled bit is the input XOR scrambled bits 14 and 17 periods earlier.
// - I and Q hold for a whole baud and change only after every second accepted bit.
// - All points have unit magnitude and carry phase only.
// - Receive finds total phase, subtracts the previous one and maps back to a dibit.
module dse_codec
  import dse_pkg::*;
(
  // Clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST_N,
  // Terminal bit stream, one strobe per bit period
  input  wire logic       BIT_STB,
  input  wire logic       BIT_IN,
  // Transmit symbol
  output dse_iq_t         TX_IQ,
  output logic            TX_SYM_STB,
  output logic            TX_SCR_BIT,
  // Receive points and recovered dibits
  input  wire logic       RX_STB,
  input  wire dse_iq_t    RX_IQ,
  output logic            RX_DIBIT_VLD,
  output logic [1:0]      RX_DIBIT
);

  typedef struct packed {
    logic [16:0] hist;
    logic        half;
    logic        first;
    dse_phase_t  phase;
    dse_iq_t     iq;
    logic        sym_stb;
    logic        scr_bit;
    logic        rx_vld;
    logic [1:0]  rx_bits;
  } dse_state_t;

  dse_state_t s_q;
  dse_state_t s_d;
  dse_dibit_t rx_dibit;
  logic       scr;
  dse_phase_t nxt_phase;

  function automatic dse_iq_t phase_to_iq(input dse_phase_t p);
    dse_iq_t r;
    r = '{i: AMP_ZERO, q: AMP_ZERO};
    case (p)
      DSE_PH_0:   r.i = AMP_POS;
      DSE_PH_90:  r.q = AMP_NEG;
      DSE_PH_180: r.i = AMP_NEG;
      default:    r.q = AMP_POS;
    endcase
    return r;
  endfunction

  // Receive path lives in its own leaf; its outputs are re-registered below.
  dse_rx_decoder u_rx (
    .clk    (SYS_CLK),
    .rst_n  (RST_N),
    .rx_stb (RX_STB),
    .rx_iq  (RX_IQ),
    .dibit  (rx_dibit)
  );

  always_comb begin
    s_d         = s_q;
    s_d.sym_stb = 1'b0;
    scr         = BIT_IN ^ s_q.hist[SCR_TAP_A-1] ^ s_q.hist[SCR_TAP_B-1];
    // Modulo 360 wraps by 2-bit overflow.
    nxt_phase   = dse_phase_t'(2'(s_q.phase + dibit_to_delta({s_q.first, scr})));
    if (BIT_STB) begin
      s_d.hist    = {s_q.hist[SCR_LEN-2:0], scr};
      s_d.scr_bit = scr;
      if (!s_q.half) begin
        s_d.first = scr;
        s_d.half  = 1'b1;
      end else begin
        // Symbol update on every second bit.
        s_d.half    = 1'b0;
        s_d.phase   = nxt_phase;
        s_d.iq      = phase_to_iq(nxt_phase);
        s_d.sym_stb = 1'b1;
      end
    end
    s_d.rx_vld  = rx_dibit.valid;
    s_d.rx_bits = rx_dibit.bits;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '{hist: SCR_RESET, half: 1'b0, first: 1'b0, phase: PHASE_RESET,
               iq: '{i: AMP_POS, q: AMP_ZERO}, sym_stb: 1'b0, scr_bit: 1'b0,
               rx_vld: 1'b0, rx_bits: 2'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign TX_IQ        = s_q.iq;
  assign TX_SYM_STB   = s_q.sym_stb;
  assign TX_SCR_BIT   = s_q.scr_bit;
  assign RX_DIBIT_VLD = s_q.rx_vld;
  assign RX_DIBIT     = s_q.rx_bits;

endmodule // dse_codec

// *** testbench/dse_codec_asserts.sv ***
// Port checker of the DPSK codec.
`timescale 1ns/1ps
module dse_codec_asserts import dse_pkg::*; (
  input wire logic       SYS_CLK, RST_N, BIT_STB, BIT_IN, TX_SYM_STB, TX_SCR_BIT,
  input wire logic       RX_STB, RX_DIBIT_VLD,
  input wire logic [1:0] RX_DIBIT,
  input wire dse_iq_t    TX_IQ, RX_IQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  function automatic logic [1:0] ph(dse_iq_t v);
    ph = v.i == 2'h1 ? 2'h0 : v.q == 2'h3 ? 2'h1 : v.i == 2'h3 ? 2'h2 : 2'h3;
  endfunction
  function automatic logic [1:0] dl(logic [1:0] d);
    dl = {d[1], d[0] ^ ~d[1]};
  endfunction
  logic [16:0] h_q;
  logic        b_q, d_q, o_q;
  logic [1:0]  r_q, e_q, e2_q;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) {h_q, b_q, d_q, o_q, r_q, e_q, e2_q} <= '0;
    else begin
      b_q <= BIT_STB;
      d_q <= BIT_IN;
      if (b_q) h_q <= {h_q[15:0], TX_SCR_BIT};
      if (BIT_STB) o_q <= ~o_q;
      if (RX_STB) r_q <= ph(RX_IQ);
      if (RX_STB) e_q <= dl(ph(RX_IQ) - r_q);
      e2_q <= e_q;
    end
  end
  property p_sym; TX_SYM_STB == $past(BIT_STB && o_q); endproperty
  a_sym: assert property (p_sym) else $error("symbol strobe off");
  property p_hold; !TX_SYM_STB |-> $stable(TX_IQ); endproperty
  a_hold: assert property (p_hold) else $error("symbol moved mid baud");
  property p_unit; TX_IQ inside {4'h4, 4'h3, 4'hc, 4'h1}; endproperty
  a_unit: assert property (p_unit) else $error("point off unit circle");
  property p_ph;
    TX_SYM_STB |-> ph(TX_IQ) == ph($past(TX_IQ)) + dl({$past(TX_SCR_BIT), TX_SCR_BIT});
  endproperty
  a_ph: assert property (p_ph) else $error("phase step wrong");
  property p_scr; b_q |-> TX_SCR_BIT == (d_q ^ h_q[13] ^ h_q[16]); endproperty
  a_scr: assert property (p_scr) else $error("scrambled bit wrong");
  property p_rst; disable iff (1'h0) !RST_N |-> TX_IQ == 4'h4 && !TX_SCR_BIT; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  sequence s_ans; ##2 RX_DIBIT_VLD; endsequence
  property p_rxlat; RX_STB |-> s_ans; endproperty
  a_rxlat: assert property (p_rxlat) else $error("no dibit after point");
  property p_rxd; RX_DIBIT_VLD |-> RX_DIBIT == e2_q && $past(RX_STB, 2); endproperty
  a_rxd: assert property (p_rxd) else $error("dibit wrong");
endmodule // dse_codec_asserts

// *** testbench/dse_dte_model.sv ***
// Terminal model sending a bit pattern on strobes with a chosen gap.
`timescale 1ns/1ps
module dse_dte_model (
  // Control
  input  wire logic        clk, start,
  input  wire logic [31:0] pat,
  input  wire logic [5:0]  n,
  input  wire logic [3:0]  gap,
  // Terminal side
  output logic             stb = 1'h0, dbit = 1'h0, busy = 1'h0
);
  logic       go;
  logic [5:0] k;
  logic [3:0] w;
  always @(posedge clk) begin
    go = start;
    #1;
    if (!go && busy && w == 4'h0) begin
      stb = 1'h1;
      dbit = pat[k];
      k = k + 6'h1;
      w = gap;
      busy = k != n;
    end else begin
      if (go) begin
        k = 6'h0;
        w = 4'h0;
        busy = 1'h1;
      end else if (busy) w = w - 4'h1;
      stb = 1'h0;
      // Idle line toggles every clock so a stale bit is never mistaken for data.
      dbit = ~dbit;
    end
  end
endmodule // dse_dte_model

// *** testbench/dse_codec_tb.sv ***
// Self-checking bench of the DPSK codec.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((e) !== (g)) begin err_total++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module dse_codec_tb import dse_pkg::*; ;
  localparam logic [15:0] IQT = 16'h1c34;
  logic        clk = 0, rst_n = 1, rstb = 0, start = 0, bstb, bin, tsym, tscr, rvld, busy;
  logic        s, nx, par, pend, pend2, r1, r2;
  logic [1:0]  rdib, ph, pe, e1, rp, rq, dd;
  logic [16:0] hs;
  logic [31:0] pat = 0;
  logic [5:0]  nb = 0;
  logic [3:0]  gap = 0;
  dse_iq_t     tiq, riq = 4'h4;
  int          err_total = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  dse_codec i_dse_codec (.SYS_CLK(clk), .RST_N(rst_n), .BIT_STB(bstb), .BIT_IN(bin),
    .TX_IQ(tiq), .TX_SYM_STB(tsym), .TX_SCR_BIT(tscr), .RX_STB(rstb), .RX_IQ(riq),
    .RX_DIBIT_VLD(rvld), .RX_DIBIT(rdib));
  dse_dte_model i_dse_dte_model (.clk(clk), .start(start), .pat(pat), .n(nb), .gap(gap),
    .stb(bstb), .dbit(bin), .busy(busy));
  always @(posedge clk) begin
    if (!rst_n) {hs, ph, par, s, rp, r1, r2, pend, pend2} = '0;
    else begin
      if (pend) `CHK("scr", s, tscr)
      if (pend2) `CHK("iq", {1'h1, IQT[ph*4 +: 4]}, {tsym, tiq})
      if (r2 || rvld) `CHK("dibit", {1'h1, pe}, {rvld, rdib})
      pend = bstb;
      pend2 = bstb && par;
      nx = bin ^ hs[13] ^ hs[16];
      if (pend2) ph = ph + {s, nx ^ ~s};
      if (bstb) {s, hs, par} = {nx, hs[15:0], nx, ~par};
      {r2, pe, r1} = {r1, e1, rstb};
      dd = rq - rp;
      if (rstb) e1 = {dd[1], dd[0] ^ ~dd[1]};
      if (rstb) rp = rq;
    end
  end
  task automatic burst(input logic [31:0] p, input logic [5:0] n, input logic [3:0] g);
    #1 {pat, nb, gap, start} = {p, n, g, 1'h1};
    @(posedge clk) #1 start = 0;
    for (int k = 0; k < 600; k++) @(posedge clk) if (!busy) break;
    if (busy) err_total++;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_b2b; burst(32'h00000001, 32, 0); $display("b2b done"); endtask
  task automatic t_gap; burst(32'hb4e12d87, 31, 3); $display("gap done"); endtask
  task automatic t_rst;
    #1 rst_n = 0;
    repeat (2) @(posedge clk);
    `CHK("rst", 5'h08, {tiq, tscr})
    #1 rst_n = 1;
    burst(32'hffffffff, 20, 1);
    $display("rst done");
  endtask
  task automatic t_rx;
    for (int k = 0; k < 5; k++) @(posedge clk) #1 {rstb, rq, riq} =
      {1'h1, 2'(8'h2d >> 2 * k), IQT[2'(8'h2d >> 2 * k) * 4 +: 4]};
    @(posedge clk) #1 {rstb, riq} = {1'h0, ~riq};
    repeat (4) @(posedge clk);
    $display("rx done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    // A falling edge is needed so the asynchronous reset really lands.
    #1 rst_n = 0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    @(posedge clk) t_b2b;
    t_gap;
    t_rst;
    t_rx;
    tally_and_finish;
  end
  initial begin
    #100us err_total++;
    tally_and_finish;
  end
endmodule // dse_codec_tb
bind dse_codec dse_codec_asserts i_dse_codec_asserts (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .BIT_STB(BIT_STB), .BIT_IN(BIT_IN), .TX_SYM_STB(TX_SYM_STB), .TX_SCR_BIT(TX_SCR_BIT),
  .RX_STB(RX_STB), .RX_DIBIT_VLD(RX_DIBIT_VLD), .RX_DIBIT(RX_DIBIT), .TX_IQ(TX_IQ),
  .RX_IQ(RX_IQ));
